//--- logic/pmr_consts.vh
// Constants for the packed move/reverse/lane ALU: APB offsets, fields, reset values, opcodes.
// Assumes a 32-bit APB slave with word-aligned registers.
// Contract
// - Copy and inverted copy with flag update set N and Z from result.
// - Copy and inverted copy with flag update take C from shifter carry.
// - Copy and inverted copy never change the V flag.
// - Load-upper-half writes its 16-bit immediate into destination bits 31..16.
// - Load-upper-half keeps destination bits 15..0 unchanged.
// - Load-upper-half changes no flag.
// - Immediate copy then load-upper-half builds any 32-bit constant.
// - Word byte swap reverses all four bytes.
// - Halfword byte swap swaps bytes inside each halfword only.
// - Low-half swap exchanges bottom bytes and sign-extends to 32 bits.
// - Bit flip puts source bit 31-i into result bit i.
// - Swap, flip, lane add and halving operations change no flag.
// - Halfword lane add does two independent 16-bit signed sums.
// - Byte lane add does four independent 8-bit signed sums.
// - Halving halfword add sums halfwords and halves each sum.
// - Halving byte add sums bytes and halves each sum.
// - Cross add-sub: top = (first top + second bottom) halved.
// - Cross add-sub: bottom = (first bottom - second top) halved.
// - Cross sub-add: bottom = (first top - second bottom) halved.
// - Cross sub-add: top = (first bottom + second top) halved.
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH

// Register byte offsets
`define PMR_OFS_OPA     12'h000
`define PMR_OFS_OPB     12'h004
`define PMR_OFS_IMM     12'h008
`define PMR_OFS_DEST    12'h00C
`define PMR_OFS_FLAGS   12'h010
`define PMR_OFS_CTRL    12'h014
`define PMR_OFS_STATUS  12'h018

// Control fields
`define PMR_CTRL_OP_HI  3
`define PMR_CTRL_OP_LO  0
`define PMR_CTRL_SETF   4
`define PMR_CTRL_COND   5
`define PMR_CTRL_CARRY  6
`define PMR_CTRL_W      7

// Flag fields
`define PMR_FLAG_N      3
`define PMR_FLAG_Z      2
`define PMR_FLAG_C      1
`define PMR_FLAG_V      0

// Status fields
`define PMR_STAT_SKIP   0
`define PMR_STAT_ILL    1

// Reset values
`define PMR_RST_WORD    32'h0000_0000
`define PMR_RST_FLAGS   4'h0
`define PMR_RST_CTRL    7'h00
`define PMR_RST_STATUS  2'h0

// Opcodes
`define PMR_OP_COPY     4'h0
`define PMR_OP_COPY_IMM 4'h1
`define PMR_OP_COPY_INV 4'h2
`define PMR_OP_LOAD_UP  4'h3
`define PMR_OP_BSW_WORD 4'h4
`define PMR_OP_BSW_HALF 4'h5
`define PMR_OP_BSW_SEXT 4'h6
`define PMR_OP_BITFLIP  4'h7
`define PMR_OP_ADD16    4'h8
`define PMR_OP_ADD8     4'h9
`define PMR_OP_HADD16   4'hA
`define PMR_OP_HADD8    4'hB
`define PMR_OP_HASX     4'hC
`define PMR_OP_HSAX     4'hD

`endif

//--- logic/pmr_alu.v
// Packed move/reverse/lane ALU with an APB register front end.
// Assumes an APB master on REF_CLK_IN; the issuer keeps operands free of stack pointer and program counter.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "pmr_consts.vh"

module pmr_alu #(
  parameter ADDR_W = 12
) (
  input  wire              REF_CLK_IN,
  input  wire              ARST_N_IN,
  input  wire              PSEL_IN,
  input  wire              PENABLE_IN,
  input  wire              PWRITE_IN,
  input  wire [ADDR_W-1:0] PADDR_IN,
  input  wire [31:0]       PWDATA_IN,
  input  wire [3:0]        PSTRB_IN,
  output reg  [31:0]       PRDATA_OUT,
  output wire              PREADY_OUT,
  output wire              PSLVERR_OUT,
  output wire [31:0]       RESULT_OUT,
  output wire [3:0]        FLAGS_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      strb_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          strb_merge[8*k +: 8] = new_v[8*k +: 8];
        end
      end
    end
  endfunction

  // Extra sign bit keeps the halved value inside the lane
  function [15:0] halve16;
    input [15:0] a;
    input [15:0] b;
    input        sub;
    reg   [16:0] s;
    begin
      s = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
      halve16 = s[16:1];
    end
  endfunction

  function [7:0] halve8;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {a[7], a} + {b[7], b};
      halve8 = s[8:1];
    end
  endfunction

  function [31:0] bit_flip;
    input [31:0] v;
    integer k;
    begin
      bit_flip = 32'h0000_0000;
      for (k = 0; k < 32; k = k + 1) begin
        bit_flip[k] = v[31-k];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [31:0]             opa_q;
  reg  [31:0]             opb_q;
  reg  [31:0]             imm_q;
  reg  [31:0]             dest_q;
  reg  [3:0]              flags_q;
  reg  [`PMR_CTRL_W-1:0]  ctrl_q;
  reg  [1:0]              status_q;
  reg  [31:0]             res_d;
  reg  [3:0]              flags_d;
  reg                     legal_d;
  reg  [31:0]             rd_d;
  reg                     hit_d;

  wire [11:0]             addr     = PADDR_IN[11:0];
  wire                    setup_ph = PSEL_IN & ~PENABLE_IN;
  wire                    wr_en    = PSEL_IN & PENABLE_IN & PWRITE_IN & hit_d;
  wire [3:0]              op       = PWDATA_IN[`PMR_CTRL_OP_HI:`PMR_CTRL_OP_LO];
  wire                    set_f    = PWDATA_IN[`PMR_CTRL_SETF];
  wire                    cond_ok  = PWDATA_IN[`PMR_CTRL_COND];
  wire                    sh_carry = PWDATA_IN[`PMR_CTRL_CARRY];
  wire                    exec     = wr_en & (addr == `PMR_OFS_CTRL) & PSTRB_IN[0];
  wire                    commit   = exec & cond_ok & legal_d;
  wire [15:0]             immediate_halfword    = imm_q[15:0];
  wire [31:0]             inv_b    = ~opb_q;
  wire [31:0]             imm_mrg  = strb_merge(imm_q, PWDATA_IN, PSTRB_IN);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux

  always @* begin
    hit_d = 1'b1;
    rd_d  = 32'h0000_0000;
    case (addr)
      `PMR_OFS_OPA:    rd_d = opa_q;
      `PMR_OFS_OPB:    rd_d = opb_q;
      `PMR_OFS_IMM:    rd_d = imm_q;
      `PMR_OFS_DEST:   rd_d = dest_q;
      `PMR_OFS_FLAGS:  rd_d = {28'h000_0000, flags_q};
      `PMR_OFS_CTRL:   rd_d = {25'h000_0000, ctrl_q};
      `PMR_OFS_STATUS: rd_d = {30'h0000_0000, status_q};
      default:         hit_d = 1'b0;
    endcase
  end

  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit_d;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  always @* begin
    res_d   = dest_q;
    flags_d = flags_q;
    legal_d = 1'b1;
    case (op)
      `PMR_OP_COPY: begin
        res_d = opb_q;
        if (set_f) begin
          flags_d[`PMR_FLAG_N] = opb_q[31];
          flags_d[`PMR_FLAG_Z] = (opb_q == 32'h0000_0000);
          flags_d[`PMR_FLAG_C] = sh_carry;
        end
      end
      `PMR_OP_COPY_IMM: begin
        res_d = {16'h0000, immediate_halfword};
      end
      `PMR_OP_COPY_INV: begin
        res_d = inv_b;
        if (set_f) begin
          flags_d[`PMR_FLAG_N] = inv_b[31];
          flags_d[`PMR_FLAG_Z] = (inv_b == 32'h0000_0000);
          flags_d[`PMR_FLAG_C] = sh_carry;
        end
      end
      `PMR_OP_LOAD_UP: begin
        res_d = {immediate_halfword, dest_q[15:0]};
      end
      `PMR_OP_BSW_WORD: begin
        res_d = {opa_q[7:0], opa_q[15:8], opa_q[23:16], opa_q[31:24]};
      end
      `PMR_OP_BSW_HALF: begin
        res_d = {opa_q[23:16], opa_q[31:24], opa_q[7:0], opa_q[15:8]};
      end
      `PMR_OP_BSW_SEXT: begin
        res_d = {{16{opa_q[7]}}, opa_q[7:0], opa_q[15:8]};
      end
      `PMR_OP_BITFLIP: begin
        res_d = bit_flip(opa_q);
      end
      `PMR_OP_ADD16: begin
        res_d = {opa_q[31:16] + opb_q[31:16], opa_q[15:0] + opb_q[15:0]};
      end
      `PMR_OP_ADD8: begin
        res_d = {opa_q[31:24] + opb_q[31:24], opa_q[23:16] + opb_q[23:16],
                 opa_q[15:8] + opb_q[15:8], opa_q[7:0] + opb_q[7:0]};
      end
      `PMR_OP_HADD16: begin
        res_d = {halve16(opa_q[31:16], opb_q[31:16], 1'b0),
                 halve16(opa_q[15:0], opb_q[15:0], 1'b0)};
      end
      `PMR_OP_HADD8: begin
        res_d = {halve8(opa_q[31:24], opb_q[31:24]), halve8(opa_q[23:16], opb_q[23:16]),
                 halve8(opa_q[15:8], opb_q[15:8]), halve8(opa_q[7:0], opb_q[7:0])};
      end
      `PMR_OP_HASX: begin
        res_d = {halve16(opa_q[31:16], opb_q[15:0], 1'b0),
                 halve16(opa_q[15:0], opb_q[31:16], 1'b1)};
      end
      `PMR_OP_HSAX: begin
        res_d = {halve16(opa_q[15:0], opb_q[31:16], 1'b0),
                 halve16(opa_q[31:16], opb_q[15:0], 1'b1)};
      end
      default: begin
        legal_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and execution

  always @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      opa_q      <= `PMR_RST_WORD;
      opb_q      <= `PMR_RST_WORD;
      imm_q      <= `PMR_RST_WORD;
      dest_q     <= `PMR_RST_WORD;
      flags_q    <= `PMR_RST_FLAGS;
      ctrl_q     <= `PMR_RST_CTRL;
      status_q   <= `PMR_RST_STATUS;
      PRDATA_OUT <= `PMR_RST_WORD;
    end else begin
      if (setup_ph & ~PWRITE_IN) begin
        PRDATA_OUT <= rd_d;
      end
      if (wr_en & (addr == `PMR_OFS_OPA)) begin
        opa_q <= strb_merge(opa_q, PWDATA_IN, PSTRB_IN);
      end
      if (wr_en & (addr == `PMR_OFS_OPB)) begin
        opb_q <= strb_merge(opb_q, PWDATA_IN, PSTRB_IN);
      end
      if (wr_en & (addr == `PMR_OFS_IMM)) begin
        imm_q <= {16'h0000, imm_mrg[15:0]};
      end
      if (wr_en & (addr == `PMR_OFS_DEST)) begin
        dest_q <= strb_merge(dest_q, PWDATA_IN, PSTRB_IN);
      end else if (commit) begin
        dest_q <= res_d;
      end
      if (wr_en & (addr == `PMR_OFS_FLAGS) & PSTRB_IN[0]) begin
        flags_q <= PWDATA_IN[3:0];
      end else if (commit) begin
        flags_q <= flags_d;
      end
      if (exec) begin
        ctrl_q <= PWDATA_IN[`PMR_CTRL_W-1:0];
      end
      // Sticky status: a new event wins over a same-cycle clear
      status_q <= (status_q & ~((wr_en & (addr == `PMR_OFS_STATUS) & PSTRB_IN[0]) ? PWDATA_IN[1:0] : 2'h0))
                | {exec & ~legal_d, exec & ~cond_ok};
    end
  end

  assign RESULT_OUT = dest_q;
  assign FLAGS_OUT  = flags_q;

endmodule

//--- verification/pmr_alu_checker.sv
// Port-level assertions for the packed move/reverse/lane ALU.
// Assumes the APB front end of pmr_alu with zero wait states.
`timescale 1ns/1ps
module pmr_alu_checker #(
  parameter ADDR_W = 12
) (
  input wire logic              REF_CLK_IN,
  input wire logic              ARST_N_IN,
  input wire logic              PSEL_IN,
  input wire logic              PENABLE_IN,
  input wire logic              PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0]       PWDATA_IN,
  input wire logic [3:0]        PSTRB_IN,
  input wire logic [31:0]       PRDATA_OUT,
  input wire logic              PREADY_OUT,
  input wire logic              PSLVERR_OUT,
  input wire logic [31:0]       RESULT_OUT,
  input wire logic [3:0]        FLAGS_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire acc    = PSEL_IN && PENABLE_IN;
  wire wr     = acc && PWRITE_IN;
  wire mapped = (PADDR_IN <= 'h18) && (PADDR_IN[1:0] == 2'h0);
  wire wr_ctl = wr && (PADDR_IN == 'h14) && PSTRB_IN[0];
  sequence s_copy_setf;
    wr_ctl && (PWDATA_IN[3:0] == 4'h0 || PWDATA_IN[3:0] == 4'h2) && PWDATA_IN[5:4] == 2'h3;
  endsequence
  sequence s_load_up;
    wr_ctl && PWDATA_IN[3:0] == 4'h3 && PWDATA_IN[5];
  endsequence
  a_ready_high: assert property (PREADY_OUT == 1'b1) else $error("ready low");
  a_err_unmapped: assert property (acc |-> PSLVERR_OUT == !mapped) else $error("slave error wrong");
  a_result_cause: assert property ($changed(RESULT_OUT) |->
    $past(wr && (PADDR_IN == 'hC || PADDR_IN == 'h14))) else $error("result changed without write");
  a_flags_cause: assert property ($changed(FLAGS_OUT) |->
    $past(wr && (PADDR_IN == 'h10 || PADDR_IN == 'h14))) else $error("flags changed without write");
  a_v_kept: assert property (wr_ctl |=> $stable(FLAGS_OUT[0])) else $error("overflow flag changed");
  a_nz_from_res: assert property (s_copy_setf |=>
    FLAGS_OUT[3:1] == {RESULT_OUT[31], RESULT_OUT == 32'h0, $past(PWDATA_IN[6])})
    else $error("copy flags wrong");
  a_upper_keep: assert property (s_load_up |=>
    RESULT_OUT[15:0] == $past(RESULT_OUT[15:0]) && $stable(FLAGS_OUT))
    else $error("upper load disturbed low half or flags");
  a_quiet_flags: assert property (wr_ctl && PWDATA_IN[3:0] >= 4'h4 |=> $stable(FLAGS_OUT))
    else $error("reverse or lane op changed flags");
  a_skip_nop: assert property (wr_ctl && !PWDATA_IN[5] |=> $stable(RESULT_OUT) && $stable(FLAGS_OUT))
    else $error("failed condition still wrote");
  a_rdata_hold: assert property (!(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |=> $stable(PRDATA_OUT))
    else $error("read data moved outside read setup");
endmodule
bind pmr_alu pmr_alu_checker #(.ADDR_W(ADDR_W)) u_chk (.REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .RESULT_OUT(RESULT_OUT), .FLAGS_OUT(FLAGS_OUT));

//--- verification/pmr_apb_master.sv
// Issuing stage model: an APB master that hands operands and commands to the ALU.
// Assumes one clock; raises hung_out when a transfer never completes.
`timescale 1ns/1ps
module pmr_apb_master (
  input  wire logic        clk_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out,
  output logic [3:0]       pstrb_out,
  output logic             hung_out
);
  initial begin
    {psel_out, penable_out, pwrite_out, hung_out} = 4'h0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
    pstrb_out = 4'hF;
  end
  // Operands only ever come from OPA/OPB/IMM/DEST, never stack or program registers
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (pready_in === 1'b1) break;
    end
    q = prdata_in;
    e = pslverr_in;
    if (n == 50) hung_out <= 1'b1;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask
endmodule

//--- verification/tb_packed_simd_move_reverse_alu.sv
// Self-checking bench for the packed move/reverse/lane ALU.
// Assumes pmr_alu, its checker and the APB master model are compiled first.
`timescale 1ns/1ps
`include "pmr_consts.vh"
module tb_packed_simd_move_reverse_alu;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, hung, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, result, a, b, rv;
  logic [3:0]  pstrb, flags;
  int          failures = 0;
  int          samples_checked = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  pmr_alu DUT (.REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RESULT_OUT(result), .FLAGS_OUT(flags));
  pmr_apb_master apb (.clk_in(ref_clk), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .pstrb_out(pstrb), .hung_out(hung));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic run(input logic [31:0] c);
    apb.wr(`PMR_OFS_CTRL, c);
    @(negedge ref_clk);
  endtask
  // Reference lane arithmetic with one guard bit per lane
  function automatic logic [31:0] ref_op(input int op, input logic [31:0] x, input logic [31:0] y);
    logic [16:0] hi, lo;
    logic [8:0]  t;
    ref_op = 32'h0;
    hi = {x[31], x[31:16]} + {y[31], y[31:16]};
    lo = {x[15], x[15:0]} + {y[15], y[15:0]};
    if (op == 12) begin
      hi = {x[31], x[31:16]} + {y[15], y[15:0]};
      lo = {x[15], x[15:0]} - {y[31], y[31:16]};
    end
    if (op == 13) begin
      lo = {x[31], x[31:16]} - {y[15], y[15:0]};
      hi = {x[15], x[15:0]} + {y[31], y[31:16]};
    end
    for (int k = 0; k < 32; k++) if (op == 7) ref_op[k] = x[31-k];
    for (int k = 0; k < 4; k++) begin
      t = {x[8*k+7], x[8*k+:8]} + {y[8*k+7], y[8*k+:8]};
      if (op == 9) ref_op[8*k+:8] = t[7:0];
      if (op == 11) ref_op[8*k+:8] = t[8:1];
    end
    case (op)
      4: ref_op = {x[7:0], x[15:8], x[23:16], x[31:24]};
      5: ref_op = {x[23:16], x[31:24], x[7:0], x[15:8]};
      6: ref_op = {{16{x[7]}}, x[7:0], x[15:8]};
      8: ref_op = {hi[15:0], lo[15:0]};
      10, 12, 13: ref_op = {hi[16:1], lo[16:1]};
      default: ;
    endcase
  endfunction
  always @(posedge hung) begin
    failures++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    apb.rd(`PMR_OFS_DEST, rv, err);
    check(rv, 32'h0);
    a = 32'h7FFF_80F7;
    b = 32'h8001_7F93;
    apb.wr(`PMR_OFS_OPA, a);
    apb.wr(`PMR_OFS_OPB, b);
    apb.wr(`PMR_OFS_FLAGS, 32'hF);
    for (int op = 4; op < 14; op++) begin
      run(32'h30 | op);
      check(result, ref_op(op, a, b));
      check({28'h0, flags}, 32'hF);
    end
    apb.wr(`PMR_OFS_OPB, 32'h0);
    apb.wr(`PMR_OFS_FLAGS, 32'h1);
    run(32'h70);
    check(result, 32'h0);
    check({28'h0, flags}, 32'h7);
    apb.wr(`PMR_OFS_OPB, 32'hF);
    run(32'h32);
    check(result, 32'hFFFF_FFF0);
    check({28'h0, flags}, 32'h9);
    apb.wr(`PMR_OFS_IMM, 32'h5678);
    run(32'h21);
    apb.wr(`PMR_OFS_IMM, 32'h1234);
    run(32'h33);
    check(result, 32'h1234_5678);
    check({28'h0, flags}, 32'h9);
    apb.wr(`PMR_OFS_DEST, 32'hAAAA_BBBB);
    run(32'h23);
    apb.rd(`PMR_OFS_DEST, rv, err);
    check(rv, 32'h1234_BBBB);
    run(32'h14);
    apb.rd(`PMR_OFS_STATUS, rv, err);
    check(result, 32'h1234_BBBB);
    check(rv, 32'h1);
    run(32'h2E);
    apb.rd(`PMR_OFS_STATUS, rv, err);
    check(result, 32'h1234_BBBB);
    check(rv, 32'h3);
    apb.wr(`PMR_OFS_STATUS, 32'h3);
    apb.rd(`PMR_OFS_STATUS, rv, err);
    check(rv, 32'h0);
    // Command write without byte 0 strobe must not execute
    @(posedge ref_clk) apb.pstrb_out <= 4'hE;
    run(32'h24);
    @(posedge ref_clk) apb.pstrb_out <= 4'hF;
    check(result, 32'h1234_BBBB);
    apb.rd(`PMR_OFS_CTRL, rv, err);
    check(rv, 32'h2E);
    apb.rd(12'h01C, rv, err);
    check(rv, 32'h0);
    check({31'h0, err}, 32'h1);
    end_sim;
  end
endmodule
